/* src/ignition_pkg.sv */
// Purpose: shared constants and state encoding for the ignition sequencer
// Assumes: core clock at 200 MHz
// Notes: intervals are held in milliseconds and converted to tick counts
package ignition_pkg;

  // ==========================================================================
  // timebase
  // ==========================================================================
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_MS = 1;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;

  // ==========================================================================
  // intervals in milliseconds
  // ==========================================================================
  localparam int unsigned SELF_CHECK_MS = 2000;
  localparam int unsigned PRE_PURGE_MS = 15000;
  localparam int unsigned WARMUP_MS = 20000;
  localparam int unsigned TRIAL_MS = 6000;
  localparam int unsigned IGN_OFF_MS = 2000;
  localparam int unsigned PROVE_WIN_MS = 2000;
  localparam int unsigned POST_PURGE_MS = 30000;
  localparam int unsigned BURN_OFF_MS = 2000;

  // ==========================================================================
  // dim flame lamp duty: on one slot out of DIM_PERIOD
  // ==========================================================================
  localparam int unsigned DIM_PERIOD = 8;
  localparam logic [2:0] DIM_ON_SLOT = 3'h0;

  // ==========================================================================
  // sequence phases
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_STANDBY = 4'h0,
    ST_SELF_CHECK = 4'h1,
    ST_AIR_WAIT = 4'h2,
    ST_PRE_PURGE = 4'h3,
    ST_WARMUP = 4'h4,
    ST_TRIAL = 4'h5,
    ST_RUN = 4'h6,
    ST_POST_PURGE = 4'h7
  } phase_e;

endpackage

/* src/tick_timebase.sv */
// Purpose: free running divider giving a one-cycle tick every DIV cycles
// Assumes: single clock, synchronous reset copy
// Notes: one tick source feeds every sequence interval
`timescale 1ns/1ps
module tick_timebase #(
  parameter int unsigned DIV = 200_000
) (
  input wire logic core_clk,
  input wire logic rst_n,
  output logic tick
);
  typedef struct packed {
    logic [31:0] cnt;
    logic tick;
  } tb_s;

  tb_s st_ff;
  tb_s nxt_st;

  initial begin
    if (DIV < 2) begin
      $error("tick_timebase: DIV must be at least 2");
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.tick = 1'b0;
    if (st_ff.cnt == 32'(DIV - 1)) begin
      nxt_st.cnt = 32'h0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.cnt = st_ff.cnt + 32'h1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign tick = st_ff.tick;
endmodule

/* src/ignition_sequence_controller.sv */
// Purpose: gas boiler light-off sequencer with five diagnostic lamps
// Assumes: thermostat, airflow switch and flame inputs are asynchronous pins
// Notes: fault, lockout and safety-switch handling live elsewhere
// Behaviour
// RULE1: idle standby lights power lamp only and waits for heat demand
// RULE2: heat demand energizes the circulator
// RULE3: two second self check, then draft inducer on
// RULE4: airflow switch closing lights purge lamp, starts 15 s pre-purge
// RULE5: after pre-purge, purge lamp off, igniter lamp and igniter on 20 s
// RULE6: after warm-up, gas valve and valve lamp on, 6 s trial begins
// RULE7: two seconds after valve opens, igniter and its lamp turn off
// RULE8: flame proving drives flame lamp dim
// RULE9: flame signal in last 2 s of trial proves flame, lamp fully lit
// RULE10: demand end drops valve and circulator, purge lamp on, 30 s post purge
// RULE11: flame lamp stays lit about 2 s into post purge
// RULE12: inducer stays on throughout post purge
// RULE13: post purge end drops inducer and returns to standby
// RULE14: all intervals from one tick counter; valve only in trial or run
`timescale 1ns/1ps
module ignition_sequence_controller
  import ignition_pkg::*;
#(
  parameter int unsigned TICK_DIV = ignition_pkg::TICK_CYCLES,
  parameter int unsigned SELF_CHECK_T = ignition_pkg::SELF_CHECK_MS / ignition_pkg::TICK_MS,
  parameter int unsigned PRE_PURGE_T = ignition_pkg::PRE_PURGE_MS / ignition_pkg::TICK_MS,
  parameter int unsigned WARMUP_T = ignition_pkg::WARMUP_MS / ignition_pkg::TICK_MS,
  parameter int unsigned TRIAL_T = ignition_pkg::TRIAL_MS / ignition_pkg::TICK_MS,
  parameter int unsigned IGN_OFF_T = ignition_pkg::IGN_OFF_MS / ignition_pkg::TICK_MS,
  parameter int unsigned PROVE_WIN_T = ignition_pkg::PROVE_WIN_MS / ignition_pkg::TICK_MS,
  parameter int unsigned POST_PURGE_T = ignition_pkg::POST_PURGE_MS / ignition_pkg::TICK_MS,
  parameter int unsigned BURN_OFF_T = ignition_pkg::BURN_OFF_MS / ignition_pkg::TICK_MS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic heat_demand,
  input wire logic airflow_ok,
  input wire logic flame_sense,
  output logic circulator_on,
  output logic inducer_on,
  output logic igniter_on,
  output logic gas_valve_on,
  output logic lamp_power,
  output logic lamp_purge,
  output logic lamp_igniter,
  output logic lamp_valve,
  output logic lamp_flame
);
  import ignition_pkg::*;

  // ==========================================================================
  // parameter checks
  // ==========================================================================
  initial begin
    if (TRIAL_T <= PROVE_WIN_T || TRIAL_T <= IGN_OFF_T || SELF_CHECK_T == 0 ||
        POST_PURGE_T <= BURN_OFF_T || PRE_PURGE_T == 0 || WARMUP_T == 0 ||
        POST_PURGE_T > 32'h0000ffff || WARMUP_T > 32'h0000ffff ||
        DIM_PERIOD != 2 ** $bits(DIM_ON_SLOT)) begin
      $error("ignition_sequence_controller: interval parameters out of range");
    end
  end

  // ==========================================================================
  // reset release and input synchronisers
  // ==========================================================================
  logic [1:0] rst_sync_ff;
  logic rst_core_n;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_core_n = rst_sync_ff[1];

  logic tick;

  tick_timebase #(
    .DIV(TICK_DIV)
  ) u_tick (
    .core_clk(core_clk),
    .rst_n(rst_core_n),
    .tick(tick)
  );

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] clean;
    phase_e phase;
    logic [15:0] tcnt;
    logic [2:0] dim_cnt;
    logic proven;
    logic circ;
    logic ind;
    logic ign;
    logic valve;
    logic l_pwr;
    logic l_purge;
    logic l_ign;
    logic l_valve;
    logic l_flame;
  } seq_s;

  seq_s st_ff;
  seq_s nxt_st;

  // ==========================================================================
  // sequencer
  // ==========================================================================
  always_comb begin
    logic demand;
    logic air;
    logic flame;
    logic [15:0] elapsed;
    logic dim_on;
    demand = 1'b0;
    air = 1'b0;
    flame = 1'b0;
    elapsed = 16'h0;
    dim_on = 1'b0;
    nxt_st = st_ff;
    // first stage feeds only the second; change accepted once stages 2 and 3 agree
    nxt_st.s1 = {heat_demand, airflow_ok, flame_sense};
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < 3; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.clean[i] = st_ff.s3[i];
      end
    end
    demand = st_ff.clean[2];
    air = st_ff.clean[1];
    flame = st_ff.clean[0];
    nxt_st.dim_cnt = st_ff.dim_cnt + 3'h1;
    dim_on = (st_ff.dim_cnt == DIM_ON_SLOT);
    // single tick counter measures every interval
    if (tick) begin // RULE14
      nxt_st.tcnt = st_ff.tcnt + 16'h1;
    end
    elapsed = st_ff.tcnt;

    unique case (st_ff.phase)
      ST_STANDBY: begin
        nxt_st.tcnt = 16'h0;
        nxt_st.proven = 1'b0;
        if (demand) begin
          nxt_st.phase = ST_SELF_CHECK;
        end
      end
      ST_SELF_CHECK: begin
        if (!demand) begin
          nxt_st.phase = ST_STANDBY;
        end else if (elapsed >= 16'(SELF_CHECK_T)) begin // RULE3
          nxt_st.phase = ST_AIR_WAIT;
          nxt_st.tcnt = 16'h0;
        end
      end
      ST_AIR_WAIT: begin
        nxt_st.tcnt = 16'h0;
        if (!demand) begin
          nxt_st.phase = ST_POST_PURGE;
        end else if (air) begin // RULE4
          nxt_st.phase = ST_PRE_PURGE;
        end
      end
      ST_PRE_PURGE: begin
        if (!demand) begin
          nxt_st.phase = ST_POST_PURGE;
          nxt_st.tcnt = 16'h0;
        end else if (elapsed >= 16'(PRE_PURGE_T)) begin // RULE5
          nxt_st.phase = ST_WARMUP;
          nxt_st.tcnt = 16'h0;
        end
      end
      ST_WARMUP: begin
        if (!demand) begin
          nxt_st.phase = ST_POST_PURGE;
          nxt_st.tcnt = 16'h0;
        end else if (elapsed >= 16'(WARMUP_T)) begin // RULE6
          nxt_st.phase = ST_TRIAL;
          nxt_st.tcnt = 16'h0;
        end
      end
      ST_TRIAL: begin
        // flame only counts inside the closing proving window
        if (flame && elapsed >= 16'(TRIAL_T - PROVE_WIN_T)) begin // RULE9
          nxt_st.proven = 1'b1;
        end
        if (!demand) begin // RULE10
          nxt_st.phase = ST_POST_PURGE;
          nxt_st.tcnt = 16'h0;
        end else if (elapsed >= 16'(TRIAL_T)) begin
          // an unproven trial simply ends; retry and lockout are handled elsewhere
          nxt_st.phase = (st_ff.proven || nxt_st.proven) ? ST_RUN : ST_POST_PURGE;
          nxt_st.tcnt = 16'h0;
        end
      end
      ST_RUN: begin
        nxt_st.tcnt = 16'h0;
        if (!demand) begin // RULE10
          nxt_st.phase = ST_POST_PURGE;
        end
      end
      ST_POST_PURGE: begin
        if (elapsed >= 16'(POST_PURGE_T)) begin // RULE13
          nxt_st.phase = ST_STANDBY;
          nxt_st.tcnt = 16'h0;
        end
      end
      default: begin
        nxt_st.phase = ST_STANDBY;
      end
    endcase

    // ========================================================================
    // outputs decoded from the next phase so they leave flip-flops aligned
    // ========================================================================
    nxt_st.l_pwr = 1'b1; // RULE1
    nxt_st.circ = demand && nxt_st.phase != ST_STANDBY &&
                  nxt_st.phase != ST_POST_PURGE; // RULE2 RULE10
    nxt_st.ind = nxt_st.phase inside {ST_AIR_WAIT, ST_PRE_PURGE, ST_WARMUP,
                                      ST_TRIAL, ST_RUN, ST_POST_PURGE}; // RULE3 RULE12
    nxt_st.l_purge = nxt_st.phase inside {ST_PRE_PURGE, ST_POST_PURGE}; // RULE4 RULE10
    nxt_st.ign = nxt_st.phase == ST_WARMUP ||
                 (nxt_st.phase == ST_TRIAL && nxt_st.tcnt < 16'(IGN_OFF_T)); // RULE5 RULE7
    nxt_st.l_ign = nxt_st.ign; // RULE5 RULE7
    nxt_st.valve = nxt_st.phase inside {ST_TRIAL, ST_RUN}; // RULE6 RULE14
    nxt_st.l_valve = nxt_st.valve; // RULE6 RULE10
    // dim once the igniter drops out of the trial, full once proven
    if (nxt_st.phase == ST_RUN || (nxt_st.phase == ST_TRIAL && nxt_st.proven)) begin // RULE9
      nxt_st.l_flame = 1'b1;
    end else if (nxt_st.phase == ST_TRIAL && !nxt_st.ign) begin // RULE8
      nxt_st.l_flame = dim_on;
    end else if (nxt_st.phase == ST_POST_PURGE && st_ff.proven &&
                 nxt_st.tcnt < 16'(BURN_OFF_T)) begin // RULE11
      nxt_st.l_flame = 1'b1;
    end else begin
      nxt_st.l_flame = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n) begin
    if (!rst_core_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign circulator_on = st_ff.circ;
  assign inducer_on = st_ff.ind;
  assign igniter_on = st_ff.ign;
  assign gas_valve_on = st_ff.valve;
  assign lamp_power = st_ff.l_pwr;
  assign lamp_purge = st_ff.l_purge;
  assign lamp_igniter = st_ff.l_ign;
  assign lamp_valve = st_ff.l_valve;
  assign lamp_flame = st_ff.l_flame;
endmodule

/* sim/ignition_checker.sv */
// Purpose: port assertions for the ignition sequencer
// Assumes: tick of 4 cycles and the short tick counts set by the bench
// Notes: windows allow one tick of slack below each interval; only the igniter-off check also bounds it from above
`timescale 1ns/1ps
module ignition_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic heat_demand,
  input wire logic airflow_ok,
  input wire logic flame_sense,
  input wire logic circulator_on,
  input wire logic inducer_on,
  input wire logic igniter_on,
  input wire logic gas_valve_on,
  input wire logic lamp_power,
  input wire logic lamp_purge,
  input wire logic lamp_igniter,
  input wire logic lamp_valve,
  input wire logic lamp_flame
);
  // ==========================================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_IDLE_LAMPS:
    assert property (lamp_power && !circulator_on && !inducer_on |->
      !lamp_purge && !lamp_igniter && !lamp_valve && !lamp_flame) else $error("idle lamps");
  AST_CIRC_ON:
    assert property (heat_demand[*8] ##1 (lamp_power && !inducer_on) |-> circulator_on)
      else $error("circulator late");
  AST_SELF_CHECK:
    assert property ($rose(inducer_on) |-> $past(circulator_on, 8)) else $error("self check");
  AST_PURGE_START:
    assert property ($rose(lamp_purge) && circulator_on |-> inducer_on && $past(airflow_ok, 2))
      else $error("purge start");
  AST_WARMUP:
    assert property ($fell(lamp_purge) && inducer_on |->
      igniter_on && lamp_igniter && $past(lamp_purge, 16)) else $error("warm-up start");
  AST_VALVE_PHASE:
    assert property (gas_valve_on |-> lamp_valve && inducer_on && circulator_on && !lamp_purge)
      else $error("valve phase");
  AST_IGN_OFF:
    assert property ($rose(gas_valve_on) |-> igniter_on[*4] ##[1:12] (!igniter_on && !lamp_igniter))
      else $error("igniter off");
  AST_FLAME_FULL:
    assert property ((lamp_flame && gas_valve_on)[*2] |-> $past(flame_sense, 3))
      else $error("flame unproven");
  AST_POST_PURGE:
    assert property ($fell(circulator_on) && inducer_on |->
      !gas_valve_on && !lamp_valve && lamp_purge) else $error("post purge start");
  AST_INDUCER_HOLD:
    assert property (lamp_purge && !circulator_on |-> inducer_on) else $error("inducer hold");
  AST_POST_END:
    assert property ($fell(inducer_on) |-> !lamp_purge && !circulator_on && $past(lamp_purge, 28))
      else $error("post purge end");
  cover property ($fell(inducer_on));
  cover property ((lamp_flame && gas_valve_on)[*2]);
  cover property ($fell(gas_valve_on) && circulator_on);
endmodule
bind ignition_sequence_controller ignition_checker chk_i (.core_clk, .rst_n, .heat_demand,
  .airflow_ok, .flame_sense, .circulator_on, .inducer_on, .igniter_on, .gas_valve_on,
  .lamp_power, .lamp_purge, .lamp_igniter, .lamp_valve, .lamp_flame);

/* sim/flue_side_model.sv */
// Purpose: airflow switch and flame sensor seen by the sequencer
// Assumes: switch closes a set delay after the inducer starts
// Notes: flame appears only while the valve is open and flame_en is set
`timescale 1ns/1ps
module flue_side_model (
  input wire logic core_clk,
  input wire logic inducer_on,
  input wire logic gas_valve_on,
  input wire logic flame_en,
  input wire logic [7:0] air_delay,
  output logic airflow_ok,
  output logic flame_sense
);
  logic [7:0] air_cnt;
  logic flame_d;
  initial begin
    air_cnt = 8'h00;
    airflow_ok = 1'b0;
    flame_d = 1'b0;
    flame_sense = 1'b0;
  end
  // switch opens at once when the fan stops, no lingering closure
  always @(posedge core_clk) begin
    air_cnt <= inducer_on ? ((air_cnt < air_delay) ? air_cnt + 8'h01 : air_cnt) : 8'h00;
    airflow_ok <= inducer_on && (air_cnt >= air_delay);
    flame_d <= flame_en && gas_valve_on;
    flame_sense <= flame_d && gas_valve_on;
  end
endmodule

/* sim/burner_ignition_sequencer_tb_top.sv */
// Purpose: self-checking bench for the ignition sequencer
// Assumes: tick of 4 cycles, shortened interval counts
// Notes: random air delays, flame outcome and aborts from a fixed seed
`timescale 1ns/1ps
module burner_ignition_sequencer_tb_top;
  logic core_clk, rst_n, heat_demand, airflow_ok, flame_sense, flame_en;
  logic circulator_on, inducer_on, igniter_on, gas_valve_on;
  logic lamp_power, lamp_purge, lamp_igniter, lamp_valve, lamp_flame;
  logic [7:0] air_delay;
  int err_count, tests_run, cyc;
  localparam int unsigned TB_TICK_DIV = 4;
  // every two-second interval except the self check shares one short count, so their relations stay as specified
  localparam int unsigned TB_TWO_S = 2;
  localparam int unsigned TB_SELF_CHECK = 3;
  localparam int unsigned TB_PURGE = 5;
  localparam int unsigned TB_TRIAL = 6;
  localparam int unsigned TB_POST = 8;
  ignition_sequence_controller #(.TICK_DIV(TB_TICK_DIV), .SELF_CHECK_T(TB_SELF_CHECK),
    .PRE_PURGE_T(TB_PURGE), .WARMUP_T(TB_PURGE), .TRIAL_T(TB_TRIAL), .IGN_OFF_T(TB_TWO_S),
    .PROVE_WIN_T(TB_TWO_S), .POST_PURGE_T(TB_POST), .BURN_OFF_T(TB_TWO_S)) uut (.core_clk,
    .rst_n, .heat_demand, .airflow_ok, .flame_sense,
    .circulator_on, .inducer_on, .igniter_on, .gas_valve_on, .lamp_power, .lamp_purge,
    .lamp_igniter, .lamp_valve, .lamp_flame);
  flue_side_model far_i (.core_clk, .inducer_on, .gas_valve_on, .flame_en, .air_delay,
    .airflow_ok, .flame_sense);
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // ==========================================================================
  // helpers
  function automatic logic pick(input int s);
    case (s)
      0: pick = circulator_on;
      1: pick = inducer_on;
      2: pick = lamp_purge;
      3: pick = igniter_on;
      default: pick = gas_valve_on;
    endcase
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic chk(input string what, input logic [4:0] exp, input logic [4:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_n(input string what, input int exp, input int got);
    tests_run++;
    if (got != exp) begin
      err_count++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  // bounded wait; a miss shows up as a compare failure, not a hang
  task automatic wait_for(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      step(1);
      n++;
    end
    chk($sformatf("wait on output %0d", s), 5'(v), 5'(pick(s)));
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================================
  // one call for heat; abort drops demand while airflow is still unproven
  task automatic run_cycle(input logic proven, input logic abort);
    int n;
    flame_en = 1'b0;
    air_delay = abort ? 8'hc8 : 8'($urandom_range(1, 20));
    heat_demand = 1'b1;
    wait_for(0, 1'b1, 10);
    chk("inducer in self check", 5'h00, 5'(inducer_on));
    wait_for(1, 1'b1, 20);
    if (abort) begin
      step(4);
      heat_demand = 1'b0;
      wait_for(0, 1'b0, 10);
      chk("post purge outputs", 5'h03, {3'h0, lamp_purge, inducer_on});
    end else begin
      wait_for(2, 1'b1, 30);
      chk("valve before trial", 5'h00, 5'(gas_valve_on));
      wait_for(2, 1'b0, 30);
      chk("warm-up outputs", 5'h03, {3'h0, igniter_on, lamp_igniter});
      wait_for(4, 1'b1, 30);
      chk("trial outputs", 5'h03, {3'h0, lamp_valve, igniter_on});
      wait_for(3, 1'b0, 16);
      flame_en = proven;
      n = 0;
      repeat (8) begin
        step(1);
        n += int'(lamp_flame === 1'b1);
      end
      chk_n("dim flame pulses", 1, n);
      if (proven) begin
        step(16);
        chk("proven flame", 5'h03, {3'h0, lamp_flame, gas_valve_on});
        step($urandom_range(5, 20));
        heat_demand = 1'b0;
        wait_for(0, 1'b0, 10);
        chk("post purge outputs", 5'h19, {lamp_purge, inducer_on, lamp_valve,
          gas_valve_on, lamp_flame});
        n = 0;
        // the burn-off lamp stands at least (count - 1) ticks plus one cycle
        repeat (TB_TICK_DIV) begin
          n += int'(lamp_flame === 1'b1);
          step(1);
        end
        chk_n("burn-off flame lamp", TB_TICK_DIV, n);
      end else begin
        wait_for(4, 1'b0, 30);
        chk("unproven purge", 5'h03, {3'h0, lamp_purge, inducer_on});
        heat_demand = 1'b0;
      end
    end
    wait_for(1, 1'b0, 60);
    chk("standby lamps", 5'h10, {lamp_power, lamp_purge, lamp_igniter, lamp_valve,
      lamp_flame});
    step(6);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_count++;
      finish_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    heat_demand = 1'b0;
    flame_en = 1'b0;
    air_delay = 8'h04;
    void'($urandom(64177));
    repeat (6) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    step(8);
    chk("idle lamps", 5'h10, {lamp_power, lamp_purge, lamp_igniter, lamp_valve,
      lamp_flame});
    // a call dropped inside the self check returns straight to standby
    heat_demand = 1'b1;
    wait_for(0, 1'b1, 10);
    heat_demand = 1'b0;
    wait_for(0, 1'b0, 10);
    chk("self check abort", 5'h10, {lamp_power, lamp_purge, lamp_igniter, lamp_valve,
      inducer_on});
    step(6);
    run_cycle(1'b1, 1'b0);
    run_cycle(1'b0, 1'b0);
    run_cycle(1'b1, 1'b1);
    repeat (3) run_cycle(1'($urandom_range(0, 1)), 1'($urandom_range(0, 3) == 0));
    finish_test();
  end
endmodule
